// >>> rtl/rdw_ring_wake.sv
// Ring detector, slot 12 indicator, ring sample coding, AC-link output and wake.
// Assumes digitised ring sense inputs on clk_sys and a controller driving bit_clk/sync.
`default_nettype none
// Function
// - Differential ring voltage compared against software-selected threshold.
// - Ring result reported via slot 12 bit, status flags and data slot.
// - Full-wave bit clear gives half-wave detection of positive ringing only.
// - Full-wave bit set detects positive and negative ringing.
// - Half-wave slot 12 bit is retriggerable one-shot of 65536 samples.
// - Off-hook event forces slot 12 ring bit to zero.
// - Full-wave slot 12 bit goes low while ringing either polarity.
// - Positive and negative flags follow voltage against the two thresholds.
// - Ring samples replace line data when link up, on-hook, no monitor.
// - Half-wave codes: -32768 idle or negative, +32767 positive.
// - Full-wave codes: +1228 idle, +32767 positive, -32768 negative.
// - Sample MSB toggles at ring frequency in both modes.
// - Ringer impedance bit selects synthesized ringer impedance.
// - In low power a ring raises SDATA_IN as wake request.
// - Wake level held until SYNC seen high then low.
// - Reset low in low power wakes by cold reset; rearm latch.
// - Low-voltage mode attenuates transmit; unattenuated bit works only in default mode.
// - Isolation link and ring data stay off until powered and rate set.
module rdw_ring_wake #(
  parameter int ONESHOT_LEN = rdw_pkg::ONESHOT_LEN,
  parameter bit LINE2 = 1'b0
) (
  // System clock, reset, enable
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic ce,
  // AC-link
  input wire logic bit_clk,
  input wire logic sync,
  output logic sdata_in,
  output logic sdata_wake,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [6:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  // Line side
  input wire logic signed [15:0] ring_sense_pos,
  input wire logic signed [15:0] ring_sense_neg,
  input wire logic [3:0] loop_current_level,
  input wire logic [15:0] line_sample,
  input wire logic offhook_req,
  input wire logic cid_monitor,
  // Controls and indications
  output logic ring_slot_indicator,
  output logic ringer_z_en,
  output logic tx_atten_en,
  output logic lowvolt_term,
  output logic dial_headroom,
  output logic link_en
);
  localparam int LB = LINE2 ? rdw_pkg::LINE2_BIT : rdw_pkg::LINE1_BIT;
  localparam logic [7:0] DS = LINE2 ? rdw_pkg::DS_LINE2 : rdw_pkg::DS_LINE1;
  localparam logic [7:0] TAG_D = LINE2 ? rdw_pkg::TAG_LINE2 : rdw_pkg::TAG_LINE1;
  localparam logic [7:0] S12_POS = rdw_pkg::S12_START + 8'(19 - LB);
  localparam logic [16:0] OS_LEN = 17'(ONESHOT_LEN);
  localparam logic [27:0] HZ = 28'(rdw_pkg::CLK_HZ);

  logic [15:0] pwr, rate, latch_sel, wake_mask, lca, lcc, word, hs_word;
  logic [16:0] cnt;
  logic [26:0] phase;
  logic pin_flag, off_q, hs_req, ack1, ack2, s1, s2, s3, sync_lvl;
  logic l_rst1, l_rst_n, l_ce1, l_ce, l_r1, l_r2, l_r3, l_i1, l_ind, l_e1, l_en, l_p1, l_pd, sync_q;
  rdw_pkg::rdw_ring_t ring;
  rdw_pkg::rdw_wake_t wst, next_wst;

  // Register decode
  wire wr_on = ce & reg_wr;
  wire wr_pwr = wr_on & (reg_addr == rdw_pkg::OFS_PWR);
  wire wr_rate = wr_on & (reg_addr == rdw_pkg::OFS_RATE);
  wire wr_latch = wr_on & (reg_addr == rdw_pkg::OFS_LATCH);
  wire wr_wake = wr_on & (reg_addr == rdw_pkg::OFS_WAKE);
  wire wr_pin = wr_on & (reg_addr == rdw_pkg::OFS_PIN);
  wire wr_lca = wr_on & (reg_addr == rdw_pkg::OFS_LCA);
  wire wr_lcc = wr_on & (reg_addr == rdw_pkg::OFS_LCC);
  wire fw = lca[rdw_pkg::LCA_FULLWAVE];
  wire [1:0] rt_sel = lca[rdw_pkg::LCA_RT_LO +: 2];
  wire [1:0] dct = lca[rdw_pkg::LCA_DCT_LO +: 2];
  wire link_pd = pwr[rdw_pkg::PWR_LINK_PD];

  // Threshold compare on the differential sense voltage
  wire signed [16:0] diff = 17'(ring_sense_pos) - 17'(ring_sense_neg);
  wire signed [16:0] th = rdw_pkg::RT_TAB[rt_sel];
  wire next_pos = diff > th;
  wire next_neg = diff < -th;

  // Sample-rate tick from the programmed rate
  wire [27:0] ph_sum = {1'b0, phase} + {12'h000, rate};
  wire tick = ph_sum >= HZ;
  wire [26:0] next_phase = tick ? 27'(ph_sum - HZ) : ph_sum[26:0];

  // One-shot and slot 12 indicator
  wire off_evt = offhook_req & ~off_q;
  wire os_load = ~fw & ring.pos;
  wire [16:0] next_cnt = off_evt ? 17'h0_0000 : os_load ? OS_LEN :
    (tick && cnt != 17'h0_0000) ? cnt - 17'h0_0001 : cnt;
  wire next_ind = off_evt ? 1'b0 :
    fw ? ~(ring.pos | ring.neg) : (next_cnt != 17'h0_0000);

  // Ring or line word for the data slot
  wire ring_mode = link_en & ~offhook_req & ~cid_monitor;
  wire [15:0] code_fw = ring.pos ? rdw_pkg::SMP_POS :
    ring.neg ? rdw_pkg::SMP_NEG : rdw_pkg::SMP_MID;
  wire [15:0] code_hw = ring.pos ? rdw_pkg::SMP_POS : rdw_pkg::SMP_NEG;
  wire [15:0] next_word = ~link_en ? 16'h0000 :
    ring_mode ? (fw ? code_fw : code_hw) : line_sample;

  // Sticky pin flag: a set in the clearing cycle wins
  wire pin_clr = wr_pin & ~reg_wdata[LB];
  wire next_pin = latch_sel[LB] ? ((pin_flag & ~pin_clr) | ring_slot_indicator) :
    ring_slot_indicator;
  wire wake_hit = pin_flag & wake_mask[LB];

  // Read mux
  wire [15:0] lsb = {8'h00, loop_current_level, 2'b00, ring.neg, ring.pos};
  wire [15:0] pin_rd = 16'(pin_flag) << LB;
  wire [15:0] rd_mux =
    (reg_addr == rdw_pkg::OFS_PWR) ? pwr :
    (reg_addr == rdw_pkg::OFS_RATE) ? rate :
    (reg_addr == rdw_pkg::OFS_LATCH) ? latch_sel :
    (reg_addr == rdw_pkg::OFS_WAKE) ? wake_mask :
    (reg_addr == rdw_pkg::OFS_PIN) ? pin_rd :
    (reg_addr == rdw_pkg::OFS_LCA) ? lca :
    (reg_addr == rdw_pkg::OFS_LSB) ? lsb :
    (reg_addr == rdw_pkg::OFS_LCC) ? lcc : 16'h0000;

  // Software registers; wake completion clears link power-down
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pwr <= rdw_pkg::RST_PWR;
      rate <= rdw_pkg::RST_ZERO;
      latch_sel <= rdw_pkg::RST_ZERO;
      wake_mask <= rdw_pkg::RST_ZERO;
      lca <= rdw_pkg::RST_LCA;
      lcc <= rdw_pkg::RST_ZERO;
    end else if (ce) begin
      if (wr_pwr) pwr <= reg_wdata;
      else if (wst == rdw_pkg::RDW_SYNC_HI && !sync_lvl) pwr[rdw_pkg::PWR_LINK_PD] <= 1'b0;
      if (wr_rate) rate <= reg_wdata;
      if (wr_latch) latch_sel <= reg_wdata;
      if (wr_wake) wake_mask <= reg_wdata;
      if (wr_lca) lca <= reg_wdata;
      if (wr_lcc) lcc <= reg_wdata;
    end
  end

  // Read answer, one cycle after the request
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 16'h0000;
      reg_rvalid <= 1'b0;
    end else if (ce) begin
      reg_rvalid <= reg_rd;
      if (reg_rd) reg_rdata <= rd_mux;
    end
  end

  // Line-side controls, registered
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ringer_z_en <= 1'b0;
      tx_atten_en <= 1'b0;
      lowvolt_term <= 1'b0;
      dial_headroom <= 1'b0;
      link_en <= 1'b0;
    end else if (ce) begin
      ringer_z_en <= lca[rdw_pkg::LCA_RZ];
      tx_atten_en <= dct == rdw_pkg::DCT_LOWV;
      lowvolt_term <= dct == rdw_pkg::DCT_LOWV ||
        (dct == rdw_pkg::DCT_DEF && lcc[rdw_pkg::LCC_UNATT]);
      dial_headroom <= lcc[rdw_pkg::LCC_DIAL];
      link_en <= pwr[rdw_pkg::PWR_CTRL_LO +: 4] == 4'h0 && rate != 16'h0000;
    end
  end

  // Detector, one-shot, sample word and pin flag
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ring <= '0;
      cnt <= 17'h0_0000;
      phase <= 27'h000_0000;
      off_q <= 1'b0;
      ring_slot_indicator <= 1'b0;
      word <= 16'h0000;
      pin_flag <= 1'b0;
    end else if (ce) begin
      ring.pos <= next_pos;
      ring.neg <= fw & next_neg;
      cnt <= next_cnt;
      phase <= next_phase;
      off_q <= offhook_req;
      ring_slot_indicator <= next_ind;
      word <= next_word;
      pin_flag <= next_pin;
    end
  end

  // Word handoff to the link domain by toggle handshake
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      hs_req <= 1'b0;
      hs_word <= 16'h0000;
    end else if (ce && tick && hs_req == ack2) begin
      hs_req <= ~hs_req;
      hs_word <= word;
    end
  end

  // Synchronisers into clk_sys: ack (2 stages), sync pin (3 stages, agree)
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      {ack1, ack2, s1, s2, s3, sync_lvl} <= 6'h00;
    end else begin
      ack1 <= l_r3;
      ack2 <= ack1;
      s1 <= sync;
      s2 <= s1;
      s3 <= s2;
      if (ce && s2 == s3) sync_lvl <= s3;
    end
  end

  // Wake sequencing
  always_comb begin
    next_wst = wst;
    case (wst)
      rdw_pkg::RDW_RUN: if (link_pd) next_wst = rdw_pkg::RDW_SLEEP;
      rdw_pkg::RDW_SLEEP: begin
        if (!link_pd) next_wst = rdw_pkg::RDW_RUN;
        else if (wake_hit) next_wst = rdw_pkg::RDW_WAKE;
      end
      rdw_pkg::RDW_WAKE: if (sync_lvl) next_wst = rdw_pkg::RDW_SYNC_HI;
      rdw_pkg::RDW_SYNC_HI: if (!sync_lvl) next_wst = rdw_pkg::RDW_RUN;
      default: next_wst = rdw_pkg::RDW_RUN;
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wst <= rdw_pkg::RDW_RUN;
      sdata_wake <= 1'b0;
    end else if (ce) begin
      wst <= next_wst;
      sdata_wake <= next_wst == rdw_pkg::RDW_WAKE || next_wst == rdw_pkg::RDW_SYNC_HI;
    end
  end

  // Link domain: reset release, enable, word and indicator capture
  logic [15:0] l_word, f_word;
  logic f_ind;
  logic [7:0] idx;
  always_ff @(posedge bit_clk or negedge arst_n) begin
    if (!arst_n) begin
      l_rst1 <= 1'b0;
      l_rst_n <= 1'b0;
    end else begin
      l_rst1 <= 1'b1;
      l_rst_n <= l_rst1;
    end
  end

  always_ff @(posedge bit_clk or negedge l_rst_n) begin
    if (!l_rst_n) begin
      {l_ce1, l_ce, l_r1, l_r2, l_r3, l_i1, l_ind, l_e1, l_en, l_p1, l_pd} <= 11'h000;
      l_word <= 16'h0000;
    end else begin
      l_ce1 <= ce;
      l_ce <= l_ce1;
      l_r1 <= hs_req;
      l_r2 <= l_r1;
      l_i1 <= ring_slot_indicator;
      l_ind <= l_i1;
      {l_en, l_e1} <= {l_e1, link_en};
      {l_pd, l_p1} <= {l_p1, link_pd};
      if (l_ce) begin
        l_r3 <= l_r2;
        if (l_r2 != l_r3) l_word <= hs_word;
      end
    end
  end

  // Frame position and serial bit; quiet while powered down so a wake edge is clean
  wire f_start = sync & ~sync_q;
  wire [7:0] cur = f_start ? 8'h00 : idx + 8'h01;
  wire [7:0] doff = cur - DS;
  wire in_data = cur >= DS && cur < DS + 8'h10;
  wire next_bit = l_pd ? 1'b0 : in_data ? f_word[4'hf - doff[3:0]] :
    (cur == S12_POS) ? f_ind :
    (cur == 8'h00 || cur == TAG_D || cur == rdw_pkg::TAG_S12) ? l_en : 1'b0;

  always_ff @(posedge bit_clk or negedge l_rst_n) begin
    if (!l_rst_n) begin
      sync_q <= 1'b0;
      idx <= 8'h00;
      f_word <= 16'h0000;
      f_ind <= 1'b0;
      sdata_in <= 1'b0;
    end else if (l_ce) begin
      sync_q <= sync;
      idx <= cur;
      if (f_start) f_word <= l_word;
      if (f_start) f_ind <= l_ind;
      sdata_in <= next_bit;
    end
  end

  // Checks in the system domain
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n || !ce);

  a_flags_exclusive: assert property (!(ring.pos && ring.neg))
    else $error("both ring flags set");
  a_half_no_neg: assert property (!fw |=> !ring.neg)
    else $error("negative flag in half-wave mode");
  a_oneshot_load: assert property (ring.pos && !fw && !off_evt |=> ring_slot_indicator)
    else $error("positive ring did not set indicator");
  a_offhook_clear: assert property (off_evt |=> !ring_slot_indicator)
    else $error("off-hook did not clear indicator");
  a_full_low: assert property (fw && (ring.pos || ring.neg) && !off_evt
    |=> !ring_slot_indicator)
    else $error("full-wave indicator not low while ringing");
  a_half_code: assert property (ring_mode && !fw && ring.pos |=> word == rdw_pkg::SMP_POS)
    else $error("half-wave positive code wrong");
  a_full_mid: assert property (ring_mode && fw && !ring.pos && !ring.neg
    |=> word == rdw_pkg::SMP_MID)
    else $error("full-wave idle code wrong");
  a_wake_rise: assert property (wst == rdw_pkg::RDW_SLEEP && link_pd && wake_hit
    |=> sdata_wake)
    else $error("wake request not raised");
  a_wake_hold: assert property ($fell(sdata_wake) |-> $past(wst) == rdw_pkg::RDW_SYNC_HI
    && !$past(sync_lvl))
    else $error("wake released before warm reset");
  a_link_gate: assert property (!link_en |=> word == 16'h0000)
    else $error("data passed with link off");
  a_oneshot_tick: assert property (tick && !os_load && !off_evt && cnt != 17'h0_0000
    |=> cnt == $past(cnt) - 17'h0_0001)
    else $error("one-shot did not step on sample tick");

  c_ring_half: cover property (!fw && ring.pos ##1 ring_slot_indicator);
  c_ring_full: cover property (fw && ring.neg ##1 word == rdw_pkg::SMP_NEG);
  c_wake_seq: cover property (wst == rdw_pkg::RDW_SYNC_HI ##1 wst == rdw_pkg::RDW_RUN);
endmodule : rdw_ring_wake
`default_nettype wire

// >>> rtl/rdw_pkg.sv
// Constants and types for the ring detect and wake block.
// Assumes a 7-bit codec register address and 16-bit register data.
`default_nettype none
package rdw_pkg;
  // Register offsets
  localparam logic [6:0] OFS_PWR = 7'h3e;
  localparam logic [6:0] OFS_RATE = 7'h40;
  localparam logic [6:0] OFS_LATCH = 7'h50;
  localparam logic [6:0] OFS_WAKE = 7'h52;
  localparam logic [6:0] OFS_PIN = 7'h54;
  localparam logic [6:0] OFS_LCA = 7'h5c;
  localparam logic [6:0] OFS_LSB = 7'h5e;
  localparam logic [6:0] OFS_LCC = 7'h62;
  // Field positions
  localparam int LINE1_BIT = 1;
  localparam int LINE2_BIT = 11;
  localparam int PWR_CTRL_LO = 8;
  localparam int PWR_LINK_PD = 12;
  localparam int LCA_RT_LO = 0;
  localparam int LCA_FULLWAVE = 2;
  localparam int LCA_RZ = 3;
  localparam int LCA_DCT_LO = 4;
  localparam int LSB_POS = 0;
  localparam int LSB_NEG = 1;
  localparam int LSB_LCS_LO = 4;
  localparam int LCC_DIAL = 0;
  localparam int LCC_UNATT = 1;
  // Reset values and termination mode codes
  localparam logic [15:0] RST_PWR = 16'h0f00;
  localparam logic [15:0] RST_LCA = 16'h0020;
  localparam logic [15:0] RST_ZERO = 16'h0000;
  localparam logic [1:0] DCT_LOWV = 2'h1;
  localparam logic [1:0] DCT_DEF = 2'h2;
  // Ring thresholds in sense units, one per select code
  localparam logic [16:0] RT_TAB [4] = '{17'h0_0800, 17'h0_1000, 17'h0_1800, 17'h0_2000};
  // Sample codes on the data slot
  localparam logic [15:0] SMP_POS = 16'h7fff;
  localparam logic [15:0] SMP_NEG = 16'h8000;
  localparam logic [15:0] SMP_MID = 16'h04cc;
  // Timing
  localparam int CLK_HZ = 125_000_000;
  localparam int ONESHOT_LEN = 65536;
  // AC-link frame bit positions
  localparam logic [7:0] DS_LINE1 = 8'h60;
  localparam logic [7:0] DS_LINE2 = 8'hc4;
  localparam logic [7:0] S12_START = 8'hec;
  localparam logic [7:0] TAG_LINE1 = 8'h05;
  localparam logic [7:0] TAG_LINE2 = 8'h0a;
  localparam logic [7:0] TAG_S12 = 8'h0c;
  typedef enum logic [1:0] {
    RDW_RUN = 2'b00, RDW_SLEEP = 2'b01, RDW_WAKE = 2'b10, RDW_SYNC_HI = 2'b11
  } rdw_wake_t;
  typedef struct packed {
    logic pos;
    logic neg;
  } rdw_ring_t;
endpackage : rdw_pkg
`default_nettype wire

// >>> dv/rdw_ctrl_model.sv
// Controller model at the far end of the AC-link: frames, sync and captured fields.
// Assumes the bench makes bit_clk and the codec drives bits on rising bit_clk.
`default_nettype none
module rdw_ctrl_model (
  // Link
  input wire logic bit_clk,
  input wire logic run,
  input wire logic sdata_in,
  input wire logic sdata_wake,
  output logic sync,
  // Captured fields
  output logic ready,
  output logic [15:0] word,
  output logic ind
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt = 8'hff;
  logic [15:0] sh = 16'h0000;
  wire logic pad = sdata_in | sdata_wake;
  wire logic in_word = cnt >= rdw_pkg::DS_LINE1 && cnt < rdw_pkg::DS_LINE1 + 8'h10;
  initial sync = 1'b0;
  // Frame count; frames stop while asleep, resuming them is the warm reset
  always @(negedge bit_clk) begin
    if (!run) begin
      cnt <= 8'hff;
      sync <= 1'b0;
    end else begin
      cnt <= cnt + 8'h01;
      sync <= (cnt == 8'hff) || (cnt < 8'h0f);
    end
  end
  // Sample returned bits mid bit, on the falling edge
  always @(negedge bit_clk) begin
    if (!run) ready <= 1'b0;
    else if (cnt == 8'h00) ready <= pad;
    if (run && in_word) sh <= {sh[14:0], pad};
    if (run && cnt == rdw_pkg::DS_LINE1 + 8'h10) word <= sh;
    if (run && cnt == rdw_pkg::S12_START + 8'h12) ind <= pad;
  end
endmodule : rdw_ctrl_model
`default_nettype wire

// >>> dv/ring_detect_and_wake_test.sv
// Testbench for the ring detect and wake block: registers, ring coding, wake.
// Assumes the package, the design and the controller model are compiled first.
`default_nettype none
module ring_detect_and_wake_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int OS = 8;
  localparam int TICK = 1908;
  localparam int W = 2 * TICK + 800;
  logic clk_sys = 1'b0;
  logic bit_clk = 1'b0;
  logic arst_n = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [6:0] reg_addr = 7'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] rpos = 16'h0000;
  logic [3:0] lcs = 4'h3;
  logic offhook_req = 1'b0;
  logic cid_monitor = 1'b0;
  logic ce = 1'b1;
  logic [15:0] rneg = 16'h0000;
  logic run = 1'b1;
  logic [15:0] reg_rdata, word;
  logic reg_rvalid, sdata_in, sdata_wake, sync, ready, ind, ring_slot_indicator;
  logic ringer_z_en, tx_atten_en, lowvolt_term, dial_headroom, link_en;
  int mismatches = 0;
  int checks_done = 0;
  // Clocks, the link clock offset in phase
  always #4 clk_sys = ~clk_sys;
  initial begin
    #1.3;
    forever #6 bit_clk = ~bit_clk;
  end
  rdw_ring_wake #(.ONESHOT_LEN(OS)) rdw_ring_wake_i (
    .clk_sys(clk_sys), .arst_n(arst_n), .ce(ce), .bit_clk(bit_clk), .sync(sync),
    .sdata_in(sdata_in), .sdata_wake(sdata_wake), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .ring_sense_pos(rpos), .ring_sense_neg(rneg),
    .loop_current_level(lcs), .line_sample(16'h1234), .offhook_req(offhook_req),
    .cid_monitor(cid_monitor), .ring_slot_indicator(ring_slot_indicator),
    .ringer_z_en(ringer_z_en), .tx_atten_en(tx_atten_en), .lowvolt_term(lowvolt_term),
    .dial_headroom(dial_headroom), .link_en(link_en));
  rdw_ctrl_model rdw_ctrl_model_i (
    .bit_clk(bit_clk), .run(run), .sdata_in(sdata_in), .sdata_wake(sdata_wake),
    .sync(sync), .ready(ready), .word(word), .ind(ind));
  // Compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : cyc
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(negedge clk_sys);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [6:0] a, input logic [15:0] e);
    @(negedge clk_sys);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    chk({15'h0000, reg_rvalid}, 16'h0001);
    chk(reg_rdata, e);
  endtask : rd
  task automatic ring(input logic [15:0] v);
    @(negedge clk_sys);
    rpos = v;
  endtask : ring
  // Ring level, then the word and slot 12 bit seen over the link
  task automatic samp(input logic [15:0] v, input logic [15:0] ew, input logic ei);
    ring(v);
    cyc(W);
    chk(word, ew);
    chk({15'h0000, ind}, {15'h0000, ei});
    chk({15'h0000, ring_slot_indicator}, {15'h0000, ei});
  endtask : samp
  task automatic t_reset;
    rd(rdw_pkg::OFS_PWR, rdw_pkg::RST_PWR);
    rd(rdw_pkg::OFS_LCA, rdw_pkg::RST_LCA);
    rd(rdw_pkg::OFS_LATCH, 16'h0000);
    rd(7'h30, 16'h0000);
    wr(rdw_pkg::OFS_RATE, 16'hffff);
    cyc(20);
    chk({15'h0000, link_en}, 16'h0000);
    wr(rdw_pkg::OFS_PWR, 16'h0000);
    cyc(20);
    chk({15'h0000, link_en}, 16'h0001);
  endtask : t_reset
  task automatic t_half;
    samp(16'hd000, rdw_pkg::SMP_NEG, 1'b0);
    samp(16'h3000, rdw_pkg::SMP_POS, 1'b1);
    samp(16'h0000, rdw_pkg::SMP_NEG, 1'b1);
    cyc((OS - 4) * TICK);
    chk({15'h0000, ring_slot_indicator}, 16'h0001);
    cyc(3 * TICK);
    chk({15'h0000, ring_slot_indicator}, 16'h0000);
  endtask : t_half
  task automatic t_wake;
    run = 1'b0;
    wr(rdw_pkg::OFS_LATCH, 16'h0002);
    wr(rdw_pkg::OFS_WAKE, 16'h0002);
    wr(rdw_pkg::OFS_PIN, 16'h0000);
    wr(rdw_pkg::OFS_PWR, 16'h1000);
    cyc(10);
    chk({15'h0000, sdata_wake}, 16'h0000);
    ring(16'h3000);
    cyc(8);
    chk({15'h0000, sdata_wake}, 16'h0001);
    ring(16'h0000);
    cyc(60);
    chk({15'h0000, sdata_wake}, 16'h0001);
    chk({15'h0000, ready}, 16'h0000);
    run = 1'b1;
    cyc(100);
    chk({15'h0000, sdata_wake}, 16'h0000);
    rd(rdw_pkg::OFS_PWR, 16'h0000);
    rd(rdw_pkg::OFS_PIN, 16'h0002);
    cyc(600);
    chk({15'h0000, ready}, 16'h0001);
  endtask : t_wake
  task automatic t_hook;
    ring(16'h3000);
    ring(16'h0000);
    cyc(4);
    offhook_req = 1'b1;
    cyc(4);
    chk({15'h0000, ring_slot_indicator}, 16'h0000);
    cyc(W);
    chk(word, 16'h1234);
    offhook_req = 1'b0;
    cid_monitor = 1'b1;
    cyc(W);
    chk(word, 16'h1234);
    cid_monitor = 1'b0;
  endtask : t_hook
  task automatic t_full;
    wr(rdw_pkg::OFS_LCA, 16'h0024);
    samp(16'h0000, rdw_pkg::SMP_MID, 1'b1);
    samp(16'h3000, rdw_pkg::SMP_POS, 1'b0);
    samp(16'hd000, rdw_pkg::SMP_NEG, 1'b0);
  endtask : t_full
  // Each threshold code: just above it, at it, and just below its negative
  task automatic t_flags;
    logic [15:0] th;
    for (int i = 0; i < 4; i++) begin
      th = rdw_pkg::RT_TAB[i][15:0];
      wr(rdw_pkg::OFS_LCA, 16'h0020 + 16'(i));
      ring(th + 16'h0001);
      rd(rdw_pkg::OFS_LSB, {8'h00, lcs, 4'h1});
      ring(th);
      rd(rdw_pkg::OFS_LSB, {8'h00, lcs, 4'h0});
      ring(16'h0000 - th - 16'h0001);
      rd(rdw_pkg::OFS_LSB, {8'h00, lcs, 4'h0});
      wr(rdw_pkg::OFS_LCA, 16'h0024 + 16'(i));
      rd(rdw_pkg::OFS_LSB, {8'h00, lcs, 4'h2});
    end
    rneg = 16'hd000;
    ring(16'h0000);
    rd(rdw_pkg::OFS_LSB, {8'h00, lcs, 4'h1});
    rneg = 16'h0000;
    ring(16'h0000);
  endtask : t_flags
  task automatic term(input logic [15:0] a, input logic [15:0] c, input logic [3:0] e);
    wr(rdw_pkg::OFS_LCA, a);
    wr(rdw_pkg::OFS_LCC, c);
    cyc(2);
    chk({12'h000, ringer_z_en, tx_atten_en, lowvolt_term, dial_headroom}, {12'h000, e});
  endtask : term
  task automatic t_term;
    term(16'h0020, 16'h0000, 4'h0);
    term(16'h0010, 16'h0002, 4'h6);
    term(16'h0020, 16'h0002, 4'h2);
    term(16'h0038, 16'h0001, 4'h9);
    ce = 1'b0;
    wr(rdw_pkg::OFS_LCC, 16'h0000);
    ce = 1'b1;
    rd(rdw_pkg::OFS_LCC, 16'h0001);
    wr(rdw_pkg::OFS_LSB, 16'hffff);
    rd(rdw_pkg::OFS_LSB, {8'h00, lcs, 4'h0});
  endtask : t_term
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done
  // Main sequence, ending with a second reset in mid-run
  initial begin
    cyc(2);
    arst_n = 1'b1;
    t_reset;
    t_half;
    t_wake;
    t_hook;
    t_full;
    t_flags;
    t_term;
    arst_n = 1'b0;
    cyc(5);
    arst_n = 1'b1;
    rd(rdw_pkg::OFS_LATCH, 16'h0000);
    test_done;
  end
  // Watchdog for a hang
  initial begin
    #700000;
    mismatches++;
    test_done;
  end
endmodule : ring_detect_and_wake_test
`default_nettype wire
